// ===== hdl/qfcs_status.v
`timescale 1ns/1ps
`default_nettype none
`include "qfcs_map.vh"

// Function
// - Freq bit0 follows synthesizer unlock
// - Freq bit1 follows 10 MHz ref unlock
// - Freq bit2 follows 1 GHz ref unlock
// - Unused condition bits read zero
// - Condition registers live, read-only, writes ignored
// - Bits absent from variant read zero in condition and event registers; filters and masks keep all written bits
// - Readback is binary weighted value
// - Rise filter bit catches 0-to-1 change
// - Fall filter bit catches 1-to-0 change
// - Event bits hold until read
// - Event read returns contents then clears
// - Freq summary is OR of enabled events
// - Cal summary goes to parent bit 8
// - Cal bit0 flags dc-coupled FM cal failure
// - Cal bit1 flags I/Q cal failure
// - Enable read returns last written mask
// - Cal events latch and clear on read
// - Cal summary is OR of enabled events
module qfcs_status #(
    parameter [15:0] FREQ_PRESENT = 16'h0007,
    parameter [15:0] CAL_PRESENT  = 16'h0003,
    parameter [15:0] RST_FILTER   = `QFCS_RST_FILTER,
    parameter [15:0] RST_MASK     = `QFCS_RST_MASK
) (
    // Clock and reset
    input  wire        CLK_SYS,
    input  wire        RESET_N,
    // Monitored status pins
    input  wire        SYNTH_UNLOCK,
    input  wire        REF10_UNLOCK,
    input  wire        REF1G_UNLOCK,
    input  wire        DC_COUPLED_FM_CAL_FAIL,
    input  wire        IQ_CAL_FAIL,
    // Register command port
    input  wire        REG_WR,
    input  wire        REG_RD,
    input  wire [3:0]  REG_SEL,
    input  wire [15:0] REG_WDATA,
    output reg  [15:0] REG_RDATA,
    output reg         REG_RVALID,
    // Summaries and validity
    output wire [15:0] QUES_SUMMARY,
    output wire        OUTPUT_INVALID
);

    // Pin synchronisers, idle low so reset makes no false edge
    wire        synth_unlock_lvl;
    wire        ref10_unlock_lvl;
    wire        ref1g_unlock_lvl;
    wire        dc_coupled_fm_fail_lvl;
    wire        iq_cal_fail_lvl;

    qfcs_sync #(
        .RST_LEVEL (1'b0)
    ) u_sync_synth (
        .clk    (CLK_SYS),
        .rst_n  (RESET_N),
        .pin_in (SYNTH_UNLOCK),
        .level  (synth_unlock_lvl)
    );

    qfcs_sync #(
        .RST_LEVEL (1'b0)
    ) u_sync_ref10 (
        .clk    (CLK_SYS),
        .rst_n  (RESET_N),
        .pin_in (REF10_UNLOCK),
        .level  (ref10_unlock_lvl)
    );

    qfcs_sync #(
        .RST_LEVEL (1'b0)
    ) u_sync_ref1g (
        .clk    (CLK_SYS),
        .rst_n  (RESET_N),
        .pin_in (REF1G_UNLOCK),
        .level  (ref1g_unlock_lvl)
    );

    qfcs_sync #(
        .RST_LEVEL (1'b0)
    ) u_sync_dc_fm (
        .clk    (CLK_SYS),
        .rst_n  (RESET_N),
        .pin_in (DC_COUPLED_FM_CAL_FAIL),
        .level  (dc_coupled_fm_fail_lvl)
    );

    qfcs_sync #(
        .RST_LEVEL (1'b0)
    ) u_sync_iq (
        .clk    (CLK_SYS),
        .rst_n  (RESET_N),
        .pin_in (IQ_CAL_FAIL),
        .level  (iq_cal_fail_lvl)
    );

    // Condition words
    reg  [15:0] freq_cond;
    reg  [15:0] cal_cond;

    always @* begin
        freq_cond = 16'h0000;
        freq_cond[`QFCS_FREQ_SYNTH_BIT] = synth_unlock_lvl;
        freq_cond[`QFCS_FREQ_REF10_BIT] = ref10_unlock_lvl;
        freq_cond[`QFCS_FREQ_CLIP_BIT]  = ref1g_unlock_lvl;
        freq_cond = freq_cond & FREQ_PRESENT & 16'h0007;
        cal_cond  = 16'h0000;
        cal_cond[`QFCS_CAL_DC_COUPLED_FM_BIT] = dc_coupled_fm_fail_lvl;
        cal_cond[`QFCS_CAL_IQ_BIT]   = iq_cal_fail_lvl;
        cal_cond = cal_cond & CAL_PRESENT & 16'h0003;
    end

    // Command decode, reads win; condition and event get no write strobe, event gets a clearing read strobe
    wire        wr_ok;
    wire        wr_freq_rise;
    wire        wr_freq_fall;
    wire        wr_freq_mask;
    wire        wr_cal_rise;
    wire        wr_cal_fall;
    wire        wr_cal_mask;
    wire        rd_freq_ev;
    wire        rd_cal_ev;

    assign wr_ok        = REG_WR & ~REG_RD;
    assign wr_freq_rise = wr_ok & (REG_SEL == `QFCS_SEL_FREQ_RISE);
    assign wr_freq_fall = wr_ok & (REG_SEL == `QFCS_SEL_FREQ_FALL);
    assign wr_freq_mask = wr_ok & (REG_SEL == `QFCS_SEL_FREQ_MASK);
    assign wr_cal_rise  = wr_ok & (REG_SEL == `QFCS_SEL_CAL_RISE);
    assign wr_cal_fall  = wr_ok & (REG_SEL == `QFCS_SEL_CAL_FALL);
    assign wr_cal_mask  = wr_ok & (REG_SEL == `QFCS_SEL_CAL_MASK);
    assign rd_freq_ev   = REG_RD & (REG_SEL == `QFCS_SEL_FREQ_EVENT);
    assign rd_cal_ev    = REG_RD & (REG_SEL == `QFCS_SEL_CAL_EVENT);

    // Per-group registers and summaries
    wire [15:0] freq_rise_filter;
    wire [15:0] freq_fall_filter;
    wire [15:0] freq_event_mask;
    wire [15:0] freq_event_latch;
    wire        freq_sum;
    wire [15:0] cal_rise_filter;
    wire [15:0] cal_fall_filter;
    wire [15:0] cal_event_mask;
    wire [15:0] cal_event_latch;
    wire        cal_sum;

    qfcs_group #(
        .WIDTH      (16),
        .PRESENT    (FREQ_PRESENT),
        .RST_FILTER (RST_FILTER),
        .RST_MASK   (RST_MASK),
        .RST_EVENT  (`QFCS_RST_EVENT)
    ) u_group_freq (
        .clk         (CLK_SYS),
        .rst_n       (RESET_N),
        .cond_in     (freq_cond),
        .wr_rise     (wr_freq_rise),
        .wr_fall     (wr_freq_fall),
        .wr_mask     (wr_freq_mask),
        .wdata       (REG_WDATA),
        .rd_event    (rd_freq_ev),
        .rise_filter (freq_rise_filter),
        .fall_filter (freq_fall_filter),
        .event_mask  (freq_event_mask),
        .event_latch (freq_event_latch),
        .summary     (freq_sum)
    );

    qfcs_group #(
        .WIDTH      (16),
        .PRESENT    (CAL_PRESENT),
        .RST_FILTER (RST_FILTER),
        .RST_MASK   (RST_MASK),
        .RST_EVENT  (`QFCS_RST_EVENT)
    ) u_group_cal (
        .clk         (CLK_SYS),
        .rst_n       (RESET_N),
        .cond_in     (cal_cond),
        .wr_rise     (wr_cal_rise),
        .wr_fall     (wr_cal_fall),
        .wr_mask     (wr_cal_mask),
        .wdata       (REG_WDATA),
        .rd_event    (rd_cal_ev),
        .rise_filter (cal_rise_filter),
        .fall_filter (cal_fall_filter),
        .event_mask  (cal_event_mask),
        .event_latch (cal_event_latch),
        .summary     (cal_sum)
    );

    // Read mux, binary weighted word
    reg [15:0] rd_mux;

    always @* begin
        case (REG_SEL)
            `QFCS_SEL_FREQ_COND:  rd_mux = freq_cond;
            `QFCS_SEL_FREQ_RISE:  rd_mux = freq_rise_filter;
            `QFCS_SEL_FREQ_FALL:  rd_mux = freq_fall_filter;
            `QFCS_SEL_FREQ_EVENT: rd_mux = freq_event_latch;
            `QFCS_SEL_FREQ_MASK:  rd_mux = freq_event_mask;
            `QFCS_SEL_CAL_COND:   rd_mux = cal_cond;
            `QFCS_SEL_CAL_RISE:   rd_mux = cal_rise_filter;
            `QFCS_SEL_CAL_FALL:   rd_mux = cal_fall_filter;
            `QFCS_SEL_CAL_EVENT:  rd_mux = cal_event_latch;
            `QFCS_SEL_CAL_MASK:   rd_mux = cal_event_mask;
            default:              rd_mux = 16'h0000;
        endcase
    end

    always @(posedge CLK_SYS or negedge RESET_N) begin
        if (!RESET_N) begin
            REG_RDATA  <= 16'h0000;
            REG_RVALID <= 1'b0;
        end else begin
            REG_RVALID <= REG_RD;
            if (REG_RD) begin
                REG_RDATA <= rd_mux;
            end
        end
    end

    // Summaries into the parent word
    assign QUES_SUMMARY = ({15'h0000, freq_sum} << `QFCS_SUM_FREQ_BIT)
                        | ({15'h0000, cal_sum} << `QFCS_SUM_CAL_BIT);
    assign OUTPUT_INVALID = cal_cond[`QFCS_CAL_DC_COUPLED_FM_BIT];

endmodule // qfcs_status

// Three-flop pin synchroniser with two-stage agreement
module qfcs_sync #(
    parameter [0:0] RST_LEVEL = 1'b0
) (
    // Clock and reset
    input  wire clk,
    input  wire rst_n,
    // Raw pin and settled level
    input  wire pin_in,
    output wire level
);

    reg stage1_r;
    reg stage2_r;
    reg stage3_r;
    reg level_r;

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stage1_r <= RST_LEVEL;
            stage2_r <= RST_LEVEL;
            stage3_r <= RST_LEVEL;
            level_r  <= RST_LEVEL;
        end else begin
            stage1_r <= pin_in;
            stage2_r <= stage1_r;
            stage3_r <= stage2_r;
            // Accept a change once stages two and three agree
            if (stage2_r == stage3_r) begin
                level_r <= stage3_r;
            end
        end
    end

    assign level = level_r;

endmodule // qfcs_sync

// One status group: edge filters, event latch, enable mask, summary
module qfcs_group #(
    parameter             WIDTH      = 16,
    parameter [WIDTH-1:0] PRESENT    = {WIDTH{1'b1}},
    parameter [WIDTH-1:0] RST_FILTER = {WIDTH{1'b0}},
    parameter [WIDTH-1:0] RST_MASK   = {WIDTH{1'b0}},
    parameter [WIDTH-1:0] RST_EVENT  = {WIDTH{1'b0}}
) (
    // Clock and reset
    input  wire             clk,
    input  wire             rst_n,
    // Live condition word
    input  wire [WIDTH-1:0] cond_in,
    // Register writes and clearing read
    input  wire             wr_rise,
    input  wire             wr_fall,
    input  wire             wr_mask,
    input  wire [WIDTH-1:0] wdata,
    input  wire             rd_event,
    // Register contents and summary
    output wire [WIDTH-1:0] rise_filter,
    output wire [WIDTH-1:0] fall_filter,
    output wire [WIDTH-1:0] event_mask,
    output wire [WIDTH-1:0] event_latch,
    output wire             summary
);

    reg  [WIDTH-1:0] prev_r;
    reg  [WIDTH-1:0] rise_filter_r;
    reg  [WIDTH-1:0] fall_filter_r;
    reg  [WIDTH-1:0] event_mask_r;
    reg  [WIDTH-1:0] event_latch_r;
    wire [WIDTH-1:0] rise_hit;
    wire [WIDTH-1:0] fall_hit;
    wire [WIDTH-1:0] kept;
    wire [WIDTH-1:0] event_nxt;

    assign rise_hit  = cond_in & ~prev_r & rise_filter_r;
    assign fall_hit  = ~cond_in & prev_r & fall_filter_r;
    assign kept      = rd_event ? {WIDTH{1'b0}} : event_latch_r;
    // Set wins over a clearing read in the same cycle
    assign event_nxt = (kept | rise_hit | fall_hit) & PRESENT;

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prev_r        <= {WIDTH{1'b0}};
            event_latch_r <= RST_EVENT;
        end else begin
            prev_r        <= cond_in;
            event_latch_r <= event_nxt;
        end
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rise_filter_r <= RST_FILTER;
            fall_filter_r <= RST_FILTER;
            event_mask_r  <= RST_MASK;
        end else begin
            if (wr_rise) begin
                rise_filter_r <= wdata;
            end
            if (wr_fall) begin
                fall_filter_r <= wdata;
            end
            if (wr_mask) begin
                event_mask_r <= wdata;
            end
        end
    end

    assign rise_filter = rise_filter_r;
    assign fall_filter = fall_filter_r;
    assign event_mask  = event_mask_r;
    assign event_latch = event_latch_r;
    assign summary     = |(event_latch_r & event_mask_r);

endmodule // qfcs_group

`default_nettype wire

// ===== hdl/qfcs_map.vh
`ifndef QFCS_MAP_VH
`define QFCS_MAP_VH

// Register selectors on the command port
`define QFCS_SEL_FREQ_COND   4'h0
`define QFCS_SEL_FREQ_RISE   4'h1
`define QFCS_SEL_FREQ_FALL   4'h2
`define QFCS_SEL_FREQ_EVENT  4'h3
`define QFCS_SEL_FREQ_MASK   4'h4
`define QFCS_SEL_CAL_COND    4'h5
`define QFCS_SEL_CAL_RISE    4'h6
`define QFCS_SEL_CAL_FALL    4'h7
`define QFCS_SEL_CAL_EVENT   4'h8
`define QFCS_SEL_CAL_MASK    4'h9

// Condition bit positions
`define QFCS_FREQ_SYNTH_BIT  0
`define QFCS_FREQ_REF10_BIT  1
`define QFCS_FREQ_CLIP_BIT   2
`define QFCS_CAL_DC_COUPLED_FM_BIT    0
`define QFCS_CAL_IQ_BIT      1

// Summary positions in the parent questionable word
`define QFCS_SUM_FREQ_BIT    5
`define QFCS_SUM_CAL_BIT     8

// Reset values
`define QFCS_RST_FILTER      16'h0000
`define QFCS_RST_MASK        16'h0000
`define QFCS_RST_EVENT       16'h0000

`endif

// ===== sim/qfcs_status_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module qfcs_status_assertions (
    // Clock and reset
    input wire logic        CLK_SYS,
    input wire logic        RESET_N,
    // Register port
    input wire logic        REG_WR,
    input wire logic        REG_RD,
    input wire logic [3:0]  REG_SEL,
    input wire logic [15:0] REG_RDATA,
    input wire logic        REG_RVALID,
    // Summaries
    input wire logic [15:0] QUES_SUMMARY,
    input wire logic        OUTPUT_INVALID
);
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (!RESET_N);
    a_read_answers: assert property (REG_RD |=> REG_RVALID)
        else $error("no answer");
    a_answer_needs_read: assert property (!REG_RD |=> !REG_RVALID)
        else $error("stray answer");
    a_summary_two_bits: assert property ((QUES_SUMMARY & 16'hfedf) == 0)
        else $error("bad summary bit");
    a_freq_event_hold: assert property ($fell(QUES_SUMMARY[5])
        |-> $past(REG_RD || REG_WR)) else $error("freq summary lost");
    a_cal_event_hold: assert property ($fell(QUES_SUMMARY[8])
        |-> $past(REG_RD || REG_WR)) else $error("cal summary lost");
    a_unknown_reads_zero: assert property ((REG_RD && REG_SEL > 4'h9)
        |=> REG_RDATA == 16'h0000) else $error("unknown not zero");
    a_freq_unused_zero: assert property ((REG_RD && REG_SEL == 4'h0)
        |=> REG_RDATA[15:3] == 13'h0000) else $error("freq unused set");
    a_cal_unused_zero: assert property ((REG_RD && REG_SEL == 4'h5)
        |=> REG_RDATA[15:2] == 14'h0000) else $error("cal unused set");
    a_invalid_readback: assert property ((REG_RD && REG_SEL == 4'h5)
        |=> REG_RDATA[0] == $past(OUTPUT_INVALID)) else $error("invalid");
    a_reset_quiet: assert property (disable iff (1'b0) !RESET_N
        |-> QUES_SUMMARY == 16'h0000 && !REG_RVALID) else $error("reset");
endmodule // qfcs_status_assertions
bind qfcs_status qfcs_status_assertions u_qfcs_status_assertions (
    .CLK_SYS(CLK_SYS), .RESET_N(RESET_N), .REG_WR(REG_WR), .REG_RD(REG_RD),
    .REG_SEL(REG_SEL), .REG_RDATA(REG_RDATA), .REG_RVALID(REG_RVALID),
    .QUES_SUMMARY(QUES_SUMMARY), .OUTPUT_INVALID(OUTPUT_INVALID));
`default_nettype wire

// ===== sim/qfcs_status_bench.sv
`timescale 1ns/1ps
`default_nettype none
module qfcs_status_bench;
    logic        clk = 0;
    logic        rst_n = 1;
    logic [4:0]  pin = 0;
    logic        wr_s = 0;
    logic        rd_s = 0;
    logic [3:0]  sel = 0;
    logic [15:0] wd = 0;
    wire  [15:0] rdata, summ;
    wire         rvalid, inval;
    int          fail_count = 0;
    int          tests_run = 0;
    int          cyc = 0;
    int          s;
    logic [15:0] sh [11];
    logic [15:0] ev_f, ev_c, got, wv;
    int          wsel [6] = '{1, 2, 4, 6, 7, 9};
    logic [4:0]  np, op;
    qfcs_status u_qfcs_status (.CLK_SYS(clk), .RESET_N(rst_n),
        .SYNTH_UNLOCK(pin[0]), .REF10_UNLOCK(pin[1]), .REF1G_UNLOCK(pin[2]),
        .DC_COUPLED_FM_CAL_FAIL(pin[3]), .IQ_CAL_FAIL(pin[4]), .REG_WR(wr_s),
        .REG_RD(rd_s), .REG_SEL(sel), .REG_WDATA(wd), .REG_RDATA(rdata),
        .REG_RVALID(rvalid), .QUES_SUMMARY(summ), .OUTPUT_INVALID(inval));
    initial forever #50 clk = ~clk;
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            $display("ERROR %0t timeout", $time);
            fail_count++;
            close_out();
        end
    end
    function automatic logic [15:0] cond(input logic [4:0] p, input bit c);
        return c ? {14'h0, p[4:3]} : {13'h0, p[2:0]};
    endfunction
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        tests_run++;
        if (g !== e) begin
            fail_count++;
            $display("ERROR %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] v);
        @(negedge clk);
        wr_s = 1;
        sel = a;
        wd = v;
        @(negedge clk);
        wr_s = 0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [15:0] v);
        @(negedge clk);
        rd_s = 1;
        sel = a;
        @(negedge clk);
        rd_s = 0;
        chk({15'h0, rvalid}, 16'h0001);
        v = rdata;
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial begin
        s = $urandom(32'h0000_e533);
        #1 rst_n = 0;
        repeat (8) @(negedge clk);
        rst_n = 1;
        // Writes land only in filters and masks
        for (int i = 0; i < 11; i++) begin
            rd(i[3:0], got);
            chk(got, 16'h0000);
            wv = 16'($urandom);
            sh[i] = (i % 5 inside {1, 2, 4}) && i < 10 ? wv : 16'h0000;
            wr(i[3:0], wv);
            rd(i[3:0], got);
            chk(got, sh[i]);
        end
        ev_f = 0;
        ev_c = 0;
        op = 0;
        repeat (60) begin
            np = 5'($urandom);
            s = wsel[$urandom % 6];
            sh[s] = 16'($urandom);
            wr(s[3:0], sh[s]);
            @(negedge clk);
            pin = np;
            repeat (6) @(negedge clk);
            ev_f |= ((~cond(op, 0) & cond(np, 0) & sh[1])
                | (cond(op, 0) & ~cond(np, 0) & sh[2]));
            ev_c |= ((~cond(op, 1) & cond(np, 1) & sh[6])
                | (cond(op, 1) & ~cond(np, 1) & sh[7]));
            op = np;
            chk(summ, {7'h0, |(ev_c & sh[9]), 2'h0, |(ev_f & sh[4]), 5'h0});
            rd(4'h0, got);
            chk(got, cond(np, 0));
            rd(4'h5, got);
            chk(got, cond(np, 1));
            chk({15'h0, inval}, {15'h0, np[3]});
            if ($urandom % 3 == 0) begin
                rd(4'h3, got);
                chk(got, ev_f);
                rd(4'h8, got);
                chk(got, ev_c);
                ev_f = 0;
                ev_c = 0;
                rd(4'h3, got);
                chk(got, 16'h0000);
            end
        end
        // Event landing on a clearing read survives it
        wr(4'h1, 16'h0001);
        wr(4'h2, 16'h0001);
        sh[1] = 16'h0001;
        sh[2] = 16'h0001;
        rd(4'h3, got);
        chk(got, ev_f);
        @(negedge clk);
        pin = op ^ 5'h01;
        repeat (3) @(negedge clk);
        rd(4'h3, got);
        chk(got, 16'h0000);
        rd(4'h3, got);
        chk(got, 16'h0001);
        close_out();
    end
endmodule // qfcs_status_bench
`default_nettype wire
